// ### hdl/ofsb_defines.svh
// constants of the output fault status bank
`ifndef OFSB_DEFINES_SVH
`define OFSB_DEFINES_SVH

// register addresses
`define OFSB_ADDR_ULD       6'h11
`define OFSB_ADDR_SUP       6'h12
`define OFSB_ADDR_CFG       6'h3f

// configuration register layout
`define OFSB_CFG_RESET      16'h0000
`define OFSB_CFG_WMASK      16'hc0ba
`define OFSB_CFG_BOOST      15
`define OFSB_CFG_RESEXT     14
`define OFSB_CFG_ECPWM      7
`define OFSB_CFG_B1H_MASK   5
`define OFSB_CFG_B1L_MASK   4
`define OFSB_CFG_TW_MASK    3
`define OFSB_CFG_ULD_MASK   1

// link frame
`define OFSB_FRAME_BITS     5'd24
`define OFSB_HDR_LAST       5'd7

// timing in ns, clock in MHz
`define OFSB_CLK_MHZ        250
`define OFSB_EC_FILTER_NS   32000
`define OFSB_ULD_FILTER_NS  100000
`define OFSB_OCR_STEP_NS    1000

`endif

// ### hdl/ofsb_pkg.sv
// types shared by the output fault status bank modules
package ofsb_pkg;
    typedef logic [5:0]  ofsb_addr_t;
    typedef logic [15:0] ofsb_word_t;
    typedef logic [7:0]  ofsb_hdr_t;
    typedef logic [15:0] ofsb_count_t;
endpackage : ofsb_pkg

// ### hdl/ofsb_link_if.sv
// decoded link frame passed from the serial slave to the register core
interface ofsb_link_if;
    import ofsb_pkg::*;
    ofsb_addr_t addr;
    logic       wr;
    logic       rc;
    ofsb_word_t wdata;
    logic       addr_stb;
    logic       frame_end;
    ofsb_word_t rdata;
    ofsb_hdr_t  hdr;

    modport spi  (output addr, wr, rc, wdata, addr_stb, frame_end, input rdata, hdr);
    modport core (input addr, wr, rc, wdata, addr_stb, frame_end, output rdata, hdr);
endinterface : ofsb_link_if

// ### hdl/ofsb_persist.sv
// persistence filter: done once cond held limit cycles
module ofsb_persist
    import ofsb_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // condition and length
    input  wire logic        cond_in,
    input  wire ofsb_count_t limit_in,
    // result
    output logic             done_out
);
    ofsb_count_t cnt_r;
    ofsb_count_t cnt_nxt;

    // any drop of the condition restarts the count
    assign cnt_nxt  = !cond_in ? '0 : (cnt_r == limit_in) ? cnt_r : cnt_r + 16'h0001;
    assign done_out = cond_in && (cnt_r == limit_in);

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end
endmodule : ofsb_persist

// ### hdl/ofsb_spi_slave.sv
// 24-bit serial link slave, oversampled by the core clock, in-frame answer
`include "ofsb_defines.svh"
module ofsb_spi_slave
    import ofsb_pkg::*;
(
    // clock and reset
    input  wire logic   clk_in,
    input  wire logic   rst_b_in,
    // link pins
    input  wire logic   spi_cs_b_in,
    input  wire logic   spi_sclk_in,
    input  wire logic   spi_sdi_in,
    output logic        spi_sdo_out,
    output logic        spi_sdo_oe_out,
    // decoded frame
    ofsb_link_if.spi    link
);
    logic [2:0]  cs_s_r;
    logic [2:0]  sclk_s_r;
    logic [1:0]  sdi_s_r;
    logic [23:0] rx_r;
    logic [23:0] tx_r;
    logic [4:0]  cnt_r;
    logic        sdo_r;
    logic        oe_r;
    logic        stb_r;
    logic        end_r;
    logic        wr_r;
    logic        rc_r;
    ofsb_addr_t  addr_r;

    wire active = !cs_s_r[1];
    wire start  = cs_s_r[2] && !cs_s_r[1];
    wire stop   = !cs_s_r[2] && cs_s_r[1];
    wire rise   = active && sclk_s_r[1] && !sclk_s_r[2];
    wire fall   = active && !sclk_s_r[1] && sclk_s_r[2];
    wire hdr_in = rise && (cnt_r == `OFSB_HDR_LAST);

    assign spi_sdo_out    = sdo_r;
    assign spi_sdo_oe_out = oe_r;
    assign link.addr      = addr_r;
    assign link.wr        = wr_r;
    assign link.rc        = rc_r;
    assign link.wdata     = rx_r[15:0];
    assign link.addr_stb  = stb_r;
    assign link.frame_end = end_r;

    ////////////////
    // pin synchronisers; stage 0 is read only by stage 1
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cs_s_r   <= 3'h7;
            sclk_s_r <= 3'h0;
            sdi_s_r  <= 2'h0;
        end
        else
        begin
            cs_s_r   <= {cs_s_r[1:0], spi_cs_b_in};
            sclk_s_r <= {sclk_s_r[1:0], spi_sclk_in};
            sdi_s_r  <= {sdi_s_r[0], spi_sdi_in};
        end
    end

    ////////////////
    // receive on rising sclk, header decoded after the eighth bit
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rx_r   <= '0;
            cnt_r  <= '0;
            stb_r  <= 1'b0;
            end_r  <= 1'b0;
            wr_r   <= 1'b0;
            rc_r   <= 1'b0;
            addr_r <= '0;
        end
        else
        begin
            stb_r <= hdr_in;
            // a short or long frame is dropped whole
            end_r <= stop && (cnt_r == `OFSB_FRAME_BITS);
            if (start)
                cnt_r <= '0;
            else if (rise && cnt_r != 5'h1f)
                cnt_r <= cnt_r + 5'h01;
            if (rise)
                rx_r <= {rx_r[22:0], sdi_s_r[1]};
            if (hdr_in)
            begin
                wr_r   <= rx_r[6];
                rc_r   <= rx_r[5];
                addr_r <= {rx_r[4:0], sdi_s_r[1]};
            end
        end
    end

    ////////////////
    // transmit: header byte first, then the addressed register, changed on falling sclk
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            tx_r  <= '0;
            sdo_r <= 1'b0;
            oe_r  <= 1'b0;
        end
        else if (start)
        begin
            sdo_r <= link.hdr[7];
            tx_r  <= {link.hdr[6:0], 17'h00000};
            oe_r  <= 1'b1;
        end
        else if (!active)
        begin
            sdo_r <= 1'b0;
            oe_r  <= 1'b0;
        end
        else if (stb_r)
            tx_r <= {link.rdata, 8'h00};
        else if (fall)
        begin
            sdo_r <= tx_r[23];
            tx_r  <= {tx_r[22:0], 1'b0};
        end
    end
endmodule : ofsb_spi_slave

// ### hdl/ofsb_top.sv
// output fault status bank: fault flags, ec status, configuration
// How it works
// - one underload flag per output; bridges in bits 15..10.
// - flag sets after low current for the filter time while on, except outputs 0 and 1 while their bridge 1 mask bit is set.
// - any underload flag sets the global underload bit.
// - mask silences only the global underload bit.
// - overcurrent on outputs 6..10 sets flag, turns output off.
// - overcurrent also sets the global supply-or-overcurrent bit.
// - with recovery, output restarts after the programmed delay, except output 10 while ec pwm discharge is on.
// - undervoltage turns all outputs off, sets its flag.
// - outputs return with supply unless latched; host clears.
// - overvoltage turns all outputs off, sets its flag.
// - same return rule after overvoltage.
// - ec code: 00 in range, 01 above, 10 below.
// - ec deviation shows only after the filter time.
// - ec bits live, set only after the filter, drop back to 00 at once.
// - ec bits never feed global bits.
// - boost enable and select give higher pwm frequency.
// - resolution bit widens pwm duty to nine bits.
// - thermal mask stops the global thermal bit.
`include "ofsb_defines.svh"
module ofsb_top
    import ofsb_pkg::*;
#(
    parameter int unsigned N_ULD             = 11,
    parameter int unsigned N_OC              = 5,
    parameter int unsigned ULD_FILTER_CYCLES = (`OFSB_ULD_FILTER_NS * `OFSB_CLK_MHZ + 999) / 1000,
    parameter int unsigned EC_FILTER_CYCLES  = (`OFSB_EC_FILTER_NS * `OFSB_CLK_MHZ + 999) / 1000,
    parameter int unsigned OCR_STEP_CYCLES   = (`OFSB_OCR_STEP_NS * `OFSB_CLK_MHZ + 999) / 1000
)
(
    // clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             rst_b_in,
    // serial link
    input  wire logic             spi_cs_b_in,
    input  wire logic             spi_sclk_in,
    input  wire logic             spi_sdi_in,
    output logic                  spi_sdo_out,
    output logic                  spi_sdo_oe_out,
    // output stage monitors
    input  wire logic [N_ULD-1:0] output_on_in,
    input  wire logic [N_ULD-1:0] undercurrent_in,
    input  wire logic [N_OC-1:0]  overcurrent_in,
    input  wire logic             vs_under_in,
    input  wire logic             vs_over_in,
    input  wire logic             thermal_warning_in,
    input  wire logic             ec_above_raw_in,
    input  wire logic             ec_below_raw_in,
    // control bits held elsewhere
    input  wire logic             ocr_enable_in,
    input  wire logic [1:0]       overcurrent_recovery_delay_in,
    input  wire logic             latch_on_supply_fault_in,
    input  wire logic             pwm_boost_select_in,
    // shutdown requests
    output logic [N_OC-1:0]       hs_off_out,
    output logic                  supply_off_out,
    // global bits and pwm options
    output logic                  global_underload_out,
    output logic                  global_supply_or_overcurrent_bit_out,
    output logic                  global_thermal_warning_out,
    output logic                  pwm_frequency_boost_out,
    output logic                  pwm_resolution_extend_out,
    output logic                  ec_lowside_pwm_discharge_out
);
    localparam int unsigned SW = N_ULD + N_OC + 5;

    ofsb_link_if link ();

    logic [SW-1:0]    sync1_r;
    logic [SW-1:0]    sync2_r;
    logic [N_ULD-1:0] uld_r;
    logic [N_OC-1:0]  oc_r;
    logic [N_OC-1:0]  off_r;
    logic             uv_r;
    logic             ov_r;
    logic             supply_off_r;
    logic [1:0]       ec_r;
    ofsb_word_t       cfg_r;
    ofsb_word_t       snap_r;
    logic             g_uld_r;
    logic             g_uovoc_r;
    logic             g_tw_r;
    logic             boost_r;

    ////////////////
    // async monitors: two flops, stage one read only by stage two
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {undercurrent_in, overcurrent_in, vs_under_in, vs_over_in,
                        thermal_warning_in, ec_above_raw_in, ec_below_raw_in};
            sync2_r <= sync1_r;
        end
    end

    wire [N_ULD-1:0] low_s   = sync2_r[SW-1 -: N_ULD];
    wire [N_OC-1:0]  trip_s  = sync2_r[N_OC+4:5];
    wire             uv_s    = sync2_r[4];
    wire             ov_s    = sync2_r[3];
    wire             tw_s    = sync2_r[2];
    wire             above_s = sync2_r[1];
    wire             below_s = sync2_r[0];

    ////////////////
    // serial link and register decode
    ofsb_spi_slave u_spi (
        .clk_in         (ref_clk_in),
        .rst_b_in       (rst_b_in),
        .spi_cs_b_in    (spi_cs_b_in),
        .spi_sclk_in    (spi_sclk_in),
        .spi_sdi_in     (spi_sdi_in),
        .spi_sdo_out    (spi_sdo_out),
        .spi_sdo_oe_out (spi_sdo_oe_out),
        .link           (link.spi)
    );

    wire sel_uld = (link.addr == `OFSB_ADDR_ULD);
    wire sel_sup = (link.addr == `OFSB_ADDR_SUP);
    wire sel_cfg = (link.addr == `OFSB_ADDR_CFG);
    wire rc_end  = link.frame_end && link.rc;
    wire cfg_wr  = link.frame_end && link.wr && sel_cfg;

    // bridge flags in upper six bits
    wire ofsb_word_t st_uld = {uld_r[0], uld_r[1], uld_r[2], uld_r[3], uld_r[4], uld_r[5], 10'h000};
    // ec code in the two low bits
    wire ofsb_word_t st_sup = {2'b00, oc_r[0], uld_r[6], oc_r[1], uld_r[7], oc_r[2], uld_r[8],
                               oc_r[3], uld_r[9], oc_r[4], uld_r[10], uv_r, ov_r, ec_r};

    assign link.rdata = sel_uld ? st_uld : sel_sup ? st_sup : sel_cfg ? cfg_r : 16'h0000;
    assign link.hdr   = {g_uld_r, g_uovoc_r, g_tw_r, 5'h00};

    // clear only bits the host was shown, so later events survive
    wire clr_uld_reg = rc_end && sel_uld;
    wire clr_sup_reg = rc_end && sel_sup;
    wire [N_ULD-1:0] clr_uld = {{5{clr_sup_reg}} & {snap_r[4], snap_r[6], snap_r[8], snap_r[10], snap_r[12]},
                                {6{clr_uld_reg}} & {snap_r[10], snap_r[11], snap_r[12],
                                                    snap_r[13], snap_r[14], snap_r[15]}};
    wire [N_OC-1:0]  clr_oc  = {5{clr_sup_reg}} & {snap_r[5], snap_r[7], snap_r[9], snap_r[11],
                                snap_r[13]};
    wire clr_uv = clr_sup_reg && snap_r[3];
    wire clr_ov = clr_sup_reg && snap_r[2];

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            snap_r <= '0;
        else if (link.addr_stb)
            snap_r <= link.rdata;
    end

    ////////////////
    // configuration register
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            cfg_r <= `OFSB_CFG_RESET;
        else if (cfg_wr)
            cfg_r <= link.wdata & `OFSB_CFG_WMASK;
    end

    ////////////////
    // underload detection per output
    wire [N_ULD-1:0] uld_hide = {{(N_ULD-2){1'b0}}, cfg_r[`OFSB_CFG_B1L_MASK], cfg_r[`OFSB_CFG_B1H_MASK]};
    wire [N_ULD-1:0] uld_set;

    genvar gi;
    generate
        for (gi = 0; gi < N_ULD; gi++)
        begin : g_uld
            // on-mode, low current for the filter time
            ofsb_persist u_flt (
                .clk_in   (ref_clk_in),
                .rst_b_in (rst_b_in),
                .cond_in  (output_on_in[gi] && low_s[gi] && !uld_hide[gi]),
                .limit_in (16'(ULD_FILTER_CYCLES)),
                .done_out (uld_set[gi])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            uld_r <= '0;
        // set wins over a clear in the same cycle
        else
            uld_r <= uld_set | (uld_r & ~clr_uld);
    end

    ////////////////
    // overcurrent shutdown and recovery per high-side output
    // the ec low side loses recovery while its pwm discharge runs
    wire [N_OC-1:0]  rec_en   = {N_OC{ocr_enable_in}} & {!cfg_r[`OFSB_CFG_ECPWM], {(N_OC-1){1'b1}}};
    wire ofsb_count_t rec_len = 16'((32'(overcurrent_recovery_delay_in) + 32'd1) * OCR_STEP_CYCLES);
    wire [N_OC-1:0]  rec_done;
    wire [N_OC-1:0]  release_off;

    generate
        for (gi = 0; gi < N_OC; gi++)
        begin : g_oc
            ofsb_persist u_rec (
                .clk_in   (ref_clk_in),
                .rst_b_in (rst_b_in),
                .cond_in  (off_r[gi] && rec_en[gi] && !trip_s[gi]),
                .limit_in (rec_len),
                .done_out (rec_done[gi])
            );
            // without recovery, held off until host clears flag
            assign release_off[gi] = rec_en[gi] ? rec_done[gi] : !oc_r[gi];
        end
    endgenerate

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            oc_r  <= '0;
            off_r <= '0;
        end
        else
        begin
            oc_r  <= trip_s | (oc_r & ~clr_oc);
            off_r <= trip_s | (off_r & ~release_off);
        end
    end

    ////////////////
    // supply faults
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            uv_r         <= 1'b0;
            ov_r         <= 1'b0;
            supply_off_r <= 1'b0;
        end
        else
        begin
            uv_r <= uv_s | (uv_r & ~clr_uv);
            ov_r <= ov_s | (ov_r & ~clr_ov);
            // latch holds outputs off until cleared
            supply_off_r <= uv_s | ov_s | (latch_on_supply_fault_in & (uv_r | ov_r));
        end
    end

    ////////////////
    // ec comparators, filtered but not latched
    wire ec_hi_ok;
    wire ec_lo_ok;

    // deviation must persist before it shows
    ofsb_persist u_ec_hi (
        .clk_in   (ref_clk_in),
        .rst_b_in (rst_b_in),
        .cond_in  (above_s && !below_s),
        .limit_in (16'(EC_FILTER_CYCLES)),
        .done_out (ec_hi_ok)
    );

    ofsb_persist u_ec_lo (
        .clk_in   (ref_clk_in),
        .rst_b_in (rst_b_in),
        .cond_in  (below_s && !above_s),
        .limit_in (16'(EC_FILTER_CYCLES)),
        .done_out (ec_lo_ok)
    );

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            ec_r <= 2'h0;
        else
            ec_r <= {ec_lo_ok, ec_hi_ok};
    end

    ////////////////
    // global bits and pwm options
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            g_uld_r   <= 1'b0;
            g_uovoc_r <= 1'b0;
            g_tw_r    <= 1'b0;
            boost_r   <= 1'b0;
        end
        else
        begin
            g_uld_r   <= (|uld_r) && !cfg_r[`OFSB_CFG_ULD_MASK];
            // overcurrent or supply only, ec excluded
            g_uovoc_r <= (|oc_r) || uv_r || ov_r;
            g_tw_r    <= tw_s && !cfg_r[`OFSB_CFG_TW_MASK];
            boost_r   <= cfg_r[`OFSB_CFG_BOOST] && pwm_boost_select_in;
        end
    end

    assign hs_off_out                           = off_r;
    assign supply_off_out                       = supply_off_r;
    assign global_underload_out                 = g_uld_r;
    assign global_supply_or_overcurrent_bit_out = g_uovoc_r;
    assign global_thermal_warning_out           = g_tw_r;
    assign pwm_frequency_boost_out              = boost_r;
    assign pwm_resolution_extend_out            = cfg_r[`OFSB_CFG_RESEXT];
    assign ec_lowside_pwm_discharge_out         = cfg_r[`OFSB_CFG_ECPWM];
endmodule : ofsb_top

// ### testbench/ofsb_top_chk.sv
// port checker of the output fault status bank
module ofsb_top_chk
    import ofsb_pkg::*;
#(
    parameter int unsigned N_OC = 5
)
(
    // clock, reset, link select
    input wire logic            ref_clk_in,
    input wire logic            rst_b_in,
    input wire logic            spi_cs_b_in,
    // monitors and control
    input wire logic [N_OC-1:0] overcurrent_in,
    input wire logic            vs_under_in,
    input wire logic            vs_over_in,
    input wire logic            ocr_enable_in,
    input wire logic [1:0]      overcurrent_recovery_delay_in,
    input wire logic            latch_on_supply_fault_in,
    // shutdown and global bits
    input wire logic [N_OC-1:0] hs_off_out,
    input wire logic            supply_off_out,
    input wire logic            global_supply_or_overcurrent_bit_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////
    // two-flop sync gives a few cycles of slack
    property p_oc_off; overcurrent_in[1] [*4] |-> ##[0:3] hs_off_out[1]; endproperty
    a_oc_off: assert property (p_oc_off) else $error("overcurrent left output on");
    property p_oc_glob; $rose(|hs_off_out) |-> ##[0:2] global_supply_or_overcurrent_bit_out; endproperty
    a_oc_glob: assert property (p_oc_glob) else $error("global fault bit missing");
    sequence s_oc_gone;
        $fell(overcurrent_in[1]) ##0 hs_off_out[1] && ocr_enable_in && overcurrent_recovery_delay_in == 2'h0;
    endsequence
    sequence s_oc_back;
        hs_off_out[1] [*3] ##[1:10] !hs_off_out[1];
    endsequence
    property p_oc_rec; s_oc_gone |=> s_oc_back; endproperty
    a_oc_rec: assert property (p_oc_rec) else $error("recovery delay wrong");
    property p_oc_hold; hs_off_out[1] && !ocr_enable_in && !spi_cs_b_in |=> hs_off_out[1]; endproperty
    a_oc_hold: assert property (p_oc_hold) else $error("output restarted by itself");
    property p_uv; vs_under_in [*4] |-> ##[0:3] supply_off_out; endproperty
    a_uv: assert property (p_uv) else $error("undervoltage left outputs on");
    property p_ov; vs_over_in [*4] |-> ##[0:3] supply_off_out; endproperty
    a_ov: assert property (p_ov) else $error("overvoltage left outputs on");
    property p_rel; (!vs_under_in && !vs_over_in && !latch_on_supply_fault_in) [*6] |-> !supply_off_out; endproperty
    a_rel: assert property (p_rel) else $error("outputs not restored");
    property p_latch; supply_off_out && latch_on_supply_fault_in && !spi_cs_b_in |=> supply_off_out; endproperty
    a_latch: assert property (p_latch) else $error("latched shutdown released");
endmodule : ofsb_top_chk

bind ofsb_top ofsb_top_chk #(.N_OC(N_OC)) u_chk (
    .ref_clk_in, .rst_b_in, .spi_cs_b_in, .overcurrent_in, .vs_under_in, .vs_over_in, .ocr_enable_in,
    .overcurrent_recovery_delay_in, .latch_on_supply_fault_in, .hs_off_out, .supply_off_out,
    .global_supply_or_overcurrent_bit_out
);

// ### testbench/ofsb_host.sv
// host model: 24-bit frame master on the serial link
module ofsb_host
    import ofsb_pkg::*;
(
    // clock
    input  wire logic ref_clk_in,
    // link pins, named as the device sees them
    output logic      spi_cs_b_in,
    output logic      spi_sclk_in,
    output logic      spi_sdi_in,
    input  wire logic spi_sdo_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        spi_cs_b_in = 1'b1;
        spi_sclk_in = 1'b0;
        spi_sdi_in  = 1'b0;
    end
    // sclk half period 20 cycles, oversampler needs 8
    task automatic xfer(input logic [23:0] f, output logic [23:0] q);
        q = 24'h000000;
        @(posedge ref_clk_in);
        spi_cs_b_in <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        for (int i = 23; i >= 0; i--)
        begin
            spi_sdi_in <= f[i];
            repeat (20) @(posedge ref_clk_in);
            spi_sclk_in <= 1'b1;
            q[i] = spi_sdo_out;
            repeat (20) @(posedge ref_clk_in);
            spi_sclk_in <= 1'b0;
        end
        repeat (20) @(posedge ref_clk_in);
        spi_cs_b_in <= 1'b1;
        // released data line must not keep looking valid
        spi_sdi_in  <= ~spi_sdi_in;
        repeat (10) @(posedge ref_clk_in);
    endtask : xfer
endmodule : ofsb_host

// ### testbench/output_fault_status_bank_test.sv
// self-checking bench of the output fault status bank
`include "ofsb_defines.svh"
module output_fault_status_bank_test
    import ofsb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ULD = 20;
    localparam int ECF = 16;
    localparam int OCR = 5;
    logic        ref_clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        spi_cs_b_in, spi_sclk_in, spi_sdi_in, spi_sdo_out, spi_sdo_oe_out;
    logic [10:0] output_on_in = 11'h000;
    logic [10:0] undercurrent_in = 11'h000;
    logic [4:0]  overcurrent_in = 5'h00;
    logic [4:0]  hs_off_out;
    logic [1:0]  overcurrent_recovery_delay_in = 2'h0;
    logic        vs_under_in = 1'b0, vs_over_in = 1'b0, thermal_warning_in = 1'b0;
    logic        ec_above_raw_in = 1'b0, ec_below_raw_in = 1'b0, ocr_enable_in = 1'b0;
    logic        latch_on_supply_fault_in = 1'b0, pwm_boost_select_in = 1'b0;
    logic        supply_off_out, global_underload_out, global_supply_or_overcurrent_bit_out;
    logic        global_thermal_warning_out, pwm_frequency_boost_out, pwm_resolution_extend_out;
    logic        ec_lowside_pwm_discharge_out;
    int          num_errors = 0;
    int          n_checks = 0;
    ofsb_word_t  d;
    ofsb_hdr_t   h;
    ofsb_top #(.ULD_FILTER_CYCLES(ULD), .EC_FILTER_CYCLES(ECF), .OCR_STEP_CYCLES(OCR)) dut (.*);
    ofsb_host host (.*);
    always #2 ref_clk_in = ~ref_clk_in;
    ////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : cyc
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rd(input ofsb_addr_t a, input logic rc);
        logic [23:0] q;
        host.xfer({1'b0, rc, a, 16'h0000}, q);
        {h, d} = q;
    endtask : rd
    task automatic wr(input ofsb_addr_t a, input ofsb_word_t v);
        logic [23:0] q;
        host.xfer({2'h2, a, v}, q);
    endtask : wr
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    ////////////////////////////////
    task automatic t_reset;
        ofsb_addr_t a [4] = '{`OFSB_ADDR_ULD, `OFSB_ADDR_SUP, `OFSB_ADDR_CFG, 6'h20};
        wr(`OFSB_ADDR_ULD, 16'hffff);
        for (int k = 0; k < 4; k++)
        begin
            rd(a[k], 1'b0);
            cmp(d, 16'h0000);
        end
        cmp(spi_sdo_oe_out, 1'b0);
    endtask : t_reset
    task automatic t_cfg;
        wr(`OFSB_ADDR_CFG, 16'hffff);
        rd(`OFSB_ADDR_CFG, 1'b0);
        cmp(d, 16'hc0ba);
        cmp(ec_lowside_pwm_discharge_out, 1'b1);
        pwm_boost_select_in <= 1'b1;
        cyc(4);
        cmp(pwm_frequency_boost_out, 1'b1);
        cmp(pwm_resolution_extend_out, 1'b1);
        wr(`OFSB_ADDR_CFG, 16'h4000);
        cmp(pwm_frequency_boost_out, 1'b0);
        pwm_boost_select_in <= 1'b0;
        wr(`OFSB_ADDR_CFG, 16'h8000);
        cmp(pwm_frequency_boost_out, 1'b0);
        cmp(pwm_resolution_extend_out, 1'b0);
        wr(`OFSB_ADDR_CFG, 16'h0000);
    endtask : t_cfg
    task automatic t_uld;
        // stage 3 is off, so its low current must not count
        output_on_in <= 11'h004;
        undercurrent_in <= 11'h00c;
        cyc(ULD + 10);
        cmp(global_underload_out, 1'b1);
        undercurrent_in <= 11'h000;
        cyc(4);
        rd(`OFSB_ADDR_ULD, 1'b1);
        cmp(d, 16'h2000);
        cmp(h[7], 1'b1);
        rd(`OFSB_ADDR_ULD, 1'b1);
        cmp(d, 16'h0000);
        wr(`OFSB_ADDR_CFG, 16'h0002);
        undercurrent_in <= 11'h004;
        cyc(ULD + 10);
        cmp(global_underload_out, 1'b0);
        undercurrent_in <= 11'h000;
        output_on_in <= 11'h000;
        rd(`OFSB_ADDR_ULD, 1'b1);
        cmp(d, 16'h2000);
        wr(`OFSB_ADDR_CFG, 16'h0000);
    endtask : t_uld
    task automatic t_oc;
        int n;
        overcurrent_in[1] <= 1'b1;
        cyc(8);
        overcurrent_in[1] <= 1'b0;
        cmp(hs_off_out[1], 1'b1);
        cmp(global_supply_or_overcurrent_bit_out, 1'b1);
        cyc(50);
        cmp(hs_off_out[1], 1'b1);
        rd(`OFSB_ADDR_SUP, 1'b1);
        cmp(d, 16'h0800);
        cmp(hs_off_out[1], 1'b0);
        ocr_enable_in <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            overcurrent_recovery_delay_in <= k[1:0];
            overcurrent_in[1] <= 1'b1;
            cyc(8);
            overcurrent_in[1] <= 1'b0;
            n = 0;
            while (hs_off_out[1] === 1'b1 && n < 100)
            begin
                cyc(1);
                n++;
            end
            if (n >= 100)
            begin
                num_errors++;
                end_of_test;
            end
            cmp(n >= (k + 1) * OCR && n <= (k + 1) * OCR + 6, 1'b1);
        end
        rd(`OFSB_ADDR_SUP, 1'b1);
        cmp(d, 16'h0800);
        ocr_enable_in <= 1'b0;
    endtask : t_oc
    task automatic t_sup;
        vs_under_in <= 1'b1;
        cyc(10);
        cmp(supply_off_out, 1'b1);
        vs_under_in <= 1'b0;
        cyc(10);
        cmp(supply_off_out, 1'b0);
        rd(`OFSB_ADDR_SUP, 1'b1);
        cmp(d, 16'h0008);
        latch_on_supply_fault_in <= 1'b1;
        vs_over_in <= 1'b1;
        cyc(10);
        vs_over_in <= 1'b0;
        cyc(10);
        cmp(supply_off_out, 1'b1);
        rd(`OFSB_ADDR_SUP, 1'b1);
        cmp(d, 16'h0004);
        cmp(supply_off_out, 1'b0);
        latch_on_supply_fault_in <= 1'b0;
    endtask : t_sup
    task automatic t_ec;
        logic [1:0] sel [3] = '{2'h1, 2'h2, 2'h3};
        ofsb_word_t exp [3] = '{16'h0001, 16'h0002, 16'h0000};
        ec_above_raw_in <= 1'b1;
        cyc(ECF / 2);
        ec_above_raw_in <= 1'b0;
        rd(`OFSB_ADDR_SUP, 1'b0);
        cmp(d, 16'h0000);
        for (int k = 0; k < 3; k++)
        begin
            {ec_below_raw_in, ec_above_raw_in} <= sel[k];
            cyc(ECF + 10);
            rd(`OFSB_ADDR_SUP, 1'b0);
            cmp(d, exp[k]);
            cmp(global_supply_or_overcurrent_bit_out, 1'b0);
        end
        {ec_below_raw_in, ec_above_raw_in} <= 2'h0;
    endtask : t_ec
    task automatic t_tw;
        thermal_warning_in <= 1'b1;
        cyc(6);
        cmp(global_thermal_warning_out, 1'b1);
        wr(`OFSB_ADDR_CFG, 16'h0008);
        cmp(global_thermal_warning_out, 1'b0);
        thermal_warning_in <= 1'b0;
        wr(`OFSB_ADDR_CFG, 16'h0000);
    endtask : t_tw
    ////////////////////////////////
    initial
    begin
        cyc(12);
        rst_b_in <= 1'b1;
        cyc(4);
        t_reset;
        t_cfg;
        t_uld;
        t_oc;
        t_sup;
        t_ec;
        t_tw;
        end_of_test;
    end
endmodule : output_fault_status_bank_test
